// ===== shared/dshd_pkg.sv
// Purpose: constants for the drive status hex display block
// Assumes: seven-segment glyphs coded {g,f,e,d,c,b,a}, segment lit = 1
// Notes:   register byte offsets are word aligned on a 32-bit apb bus
package dshd_pkg;
  // status word bit positions
  localparam int unsigned BIT_BUSY   = 15;
  localparam int unsigned BIT_ZERO_H = 14;
  localparam int unsigned BIT_ZERO_L = 13;
  localparam int unsigned BIT_COMM   = 12;
  localparam int unsigned BIT_ALARM  = 11;
  localparam int unsigned BIT_DECEL  = 10;
  localparam int unsigned BIT_ACCEL  = 9;
  localparam int unsigned BIT_ILIM   = 8;
  localparam int unsigned BIT_VLIM   = 7;
  localparam int unsigned BIT_TLIM   = 6;
  localparam int unsigned BIT_NUV    = 5;
  localparam int unsigned BIT_BRAKE  = 4;
  localparam int unsigned BIT_SHUT   = 3;
  localparam int unsigned BIT_DCBRK  = 2;
  localparam int unsigned BIT_REV    = 1;
  localparam int unsigned BIT_FWD    = 0;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PANEL  = 8'h08;

  // menu scope values and reset value
  localparam logic [1:0] SCOPE_FULL  = 2'h2;
  localparam logic [1:0] SCOPE_RESET = 2'h0;

  // menu numbers and item limits
  localparam logic [2:0] MENU_LAST    = 3'h7;
  localparam logic [2:0] MENU_DRIVE   = 3'h3;
  localparam logic [2:0] MENU_IO      = 3'h4;
  localparam logic [4:0] ITEM_RUNSTAT = 5'h07;
  localparam logic [4:0] ITEM_IO_TERM = 5'h00;
  localparam logic [4:0] ITEM_IO_COMM = 5'h01;
  localparam logic [4:0] ITEM_LAST_DRV = 5'h0d;
  localparam logic [4:0] ITEM_LAST_IO  = 5'h12;
  localparam logic [4:0] ITEM_LAST_OTH = 5'h0f;

  // glyphs
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_DASH  = 7'h40;
  localparam logic [6:0] SEG_UNDER = 7'h08;
  localparam logic [6:0] SEG_0 = 7'h3f;
  localparam logic [6:0] SEG_1 = 7'h06;
  localparam logic [6:0] SEG_2 = 7'h5b;
  localparam logic [6:0] SEG_3 = 7'h4f;
  localparam logic [6:0] SEG_4 = 7'h66;
  localparam logic [6:0] SEG_5 = 7'h6d;
  localparam logic [6:0] SEG_6 = 7'h7d;
  localparam logic [6:0] SEG_7 = 7'h07;
  localparam logic [6:0] SEG_8 = 7'h7f;
  localparam logic [6:0] SEG_9 = 7'h6f;
  localparam logic [6:0] SEG_A = 7'h77;
  localparam logic [6:0] SEG_B = 7'h7c;
  localparam logic [6:0] SEG_C = 7'h39;
  localparam logic [6:0] SEG_D = 7'h5e;
  localparam logic [6:0] SEG_E = 7'h79;
  localparam logic [6:0] SEG_F = 7'h71;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_MENU = 4'b0010,
    ST_LIST = 4'b0100,
    ST_SHOW = 4'b1000
  } dshd_state_t;
endpackage

// ===== rtl/dshd_top.sv
// Purpose: running status word, hex panel display and keypad menu walk
// Assumes: key inputs are one-cycle pulses synchronous to i_ref_clk
// Notes:   apb slave, zero wait states beyond the access phase
// Notes on behaviour
// - bit 15 set while parameters are written; bits 14 and 13 always zero.
// - bit 12 set while the communications link may command run and frequency.
// - bit 11 follows the alarm condition.
// - bit 10 set while decelerating, bit 9 while accelerating.
// - bit 8 set while current limiting is active.
// - bit 7 set while voltage limiting is active.
// - bit 6 set while torque limiting is active.
// - bit 5 set while bus voltage is above the undervoltage level.
// - bit 4 set during any braking, bit 2 during dc braking.
// - bit 3 set while the output stage is shut down.
// - bit 1 set while running in reverse.
// - bit 0 set while running forward.
// - 16-bit word; leftmost digit shows bits 15..12, rightmost 3..0.
// - each nibble shown as one hex glyph, b and d in lower case.
// - start in running mode; enter key opens the function menu.
// - up and down toggle segment or hex view for I/O items 0 and 1.
// - return goes to item list, a second return to the function menu.
// - running status is a selectable hex item of the monitoring menu.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dshd_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_param_writing,
  input  wire logic        i_comm_link_ready,
  input  wire logic        i_alarm_flag,
  input  wire logic        i_slowing_down,
  input  wire logic        i_speeding_up,
  input  wire logic        i_current_limit_active,
  input  wire logic        i_voltage_limit_active,
  input  wire logic        i_torque_limit_active,
  input  wire logic        i_bus_above_undervoltage,
  input  wire logic        i_braking_active,
  input  wire logic        i_output_shutdown,
  input  wire logic        i_dc_brake_active,
  input  wire logic        i_backward_run,
  input  wire logic        i_forward_run,
  input  wire logic [15:0] i_io_terminals,
  input  wire logic [15:0] i_io_comm_terminals,
  input  wire logic        i_key_enter,
  input  wire logic        i_key_return,
  input  wire logic        i_key_up,
  input  wire logic        i_key_down,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [15:0] o_status_word,
  output logic      [6:0]  o_led4,
  output logic      [6:0]  o_led3,
  output logic      [6:0]  o_led2,
  output logic      [6:0]  o_led1,
  output logic             o_prog_mode
);
  function automatic logic [6:0] hex2seg(input logic [3:0] n);
    logic [6:0] s;
    s = dshd_pkg::SEG_0;
    case (n)
      4'h0: s = dshd_pkg::SEG_0;
      4'h1: s = dshd_pkg::SEG_1;
      4'h2: s = dshd_pkg::SEG_2;
      4'h3: s = dshd_pkg::SEG_3;
      4'h4: s = dshd_pkg::SEG_4;
      4'h5: s = dshd_pkg::SEG_5;
      4'h6: s = dshd_pkg::SEG_6;
      4'h7: s = dshd_pkg::SEG_7;
      4'h8: s = dshd_pkg::SEG_8;
      4'h9: s = dshd_pkg::SEG_9;
      4'ha: s = dshd_pkg::SEG_A;
      4'hb: s = dshd_pkg::SEG_B;
      4'hc: s = dshd_pkg::SEG_C;
      4'hd: s = dshd_pkg::SEG_D;
      4'he: s = dshd_pkg::SEG_E;
      default: s = dshd_pkg::SEG_F;
    endcase
    return s;
  endfunction

  // segment view: each nibble bit lights one segment a..d of its digit
  function automatic logic [6:0] nib2bar(input logic [3:0] n);
    return (n == 4'h0) ? dshd_pkg::SEG_DASH : {3'h0, n};
  endfunction

  // ---------------- status word ----------------
  logic [15:0] status_d;
  logic [15:0] status_q;
  assign status_d[dshd_pkg::BIT_BUSY]   = i_param_writing;
  assign status_d[dshd_pkg::BIT_ZERO_H] = 1'b0;
  assign status_d[dshd_pkg::BIT_ZERO_L] = 1'b0;
  assign status_d[dshd_pkg::BIT_COMM]   = i_comm_link_ready;
  assign status_d[dshd_pkg::BIT_ALARM]  = i_alarm_flag;
  assign status_d[dshd_pkg::BIT_DECEL]  = i_slowing_down;
  assign status_d[dshd_pkg::BIT_ACCEL]  = i_speeding_up;
  assign status_d[dshd_pkg::BIT_ILIM]   = i_current_limit_active;
  assign status_d[dshd_pkg::BIT_VLIM]   = i_voltage_limit_active;
  assign status_d[dshd_pkg::BIT_TLIM]   = i_torque_limit_active;
  assign status_d[dshd_pkg::BIT_NUV]    = i_bus_above_undervoltage;
  assign status_d[dshd_pkg::BIT_BRAKE]  = i_braking_active;
  assign status_d[dshd_pkg::BIT_DCBRK]  = i_dc_brake_active;
  assign status_d[dshd_pkg::BIT_SHUT]   = i_output_shutdown;
  assign status_d[dshd_pkg::BIT_REV]    = i_backward_run;
  assign status_d[dshd_pkg::BIT_FWD]    = i_forward_run;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= status_d;
    end
  end
  assign o_status_word = status_q;

  // ---------------- apb slave ----------------
  logic [1:0]  scope_q;
  logic        setup_w;
  logic        access_w;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_panel;
  logic        hit_any;
  logic [31:0] rdata_w;
  dshd_pkg::dshd_state_t st_q;
  dshd_pkg::dshd_state_t st_d;
  logic [2:0]  menu_q;
  logic [4:0]  item_q;
  logic        hex_q;

  assign setup_w   = i_psel & ~i_penable;
  assign access_w  = i_psel & i_penable & o_pready;
  assign hit_ctrl  = (i_paddr == dshd_pkg::OFS_CTRL);
  assign hit_stat  = (i_paddr == dshd_pkg::OFS_STATUS);
  assign hit_panel = (i_paddr == dshd_pkg::OFS_PANEL);
  assign hit_any   = hit_ctrl | hit_stat | hit_panel;
  assign rdata_w   = hit_ctrl  ? {30'h0, scope_q} :
                     hit_stat  ? {16'h0, status_q} :
                     hit_panel ? {19'h0, hex_q, item_q, menu_q, st_q} : 32'h0000_0000;

  // read data and error are latched in setup so outputs come from flops
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup_w;
      o_pslverr <= setup_w & ~hit_any;
      o_prdata  <= (setup_w & ~i_pwrite) ? rdata_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scope_q <= dshd_pkg::SCOPE_RESET;
    end else if (access_w & i_pwrite & hit_ctrl) begin
      scope_q <= i_pwdata[1:0];
    end
  end

  // ---------------- keypad menu ----------------
  logic [4:0] item_last;
  logic       menu_open_ok;
  logic       io_toggle_item;
  logic       show_stat;
  logic       show_io;

  assign item_last = (menu_q == dshd_pkg::MENU_DRIVE) ? dshd_pkg::ITEM_LAST_DRV :
                     (menu_q == dshd_pkg::MENU_IO)    ? dshd_pkg::ITEM_LAST_IO :
                                                        dshd_pkg::ITEM_LAST_OTH;
  assign menu_open_ok = ((menu_q != dshd_pkg::MENU_DRIVE) && (menu_q != dshd_pkg::MENU_IO))
                        || (scope_q == dshd_pkg::SCOPE_FULL);
  assign io_toggle_item = (menu_q == dshd_pkg::MENU_IO) &&
                          ((item_q == dshd_pkg::ITEM_IO_TERM) ||
                           (item_q == dshd_pkg::ITEM_IO_COMM));
  assign show_stat = (st_q == dshd_pkg::ST_SHOW) && (menu_q == dshd_pkg::MENU_DRIVE) &&
                     (item_q == dshd_pkg::ITEM_RUNSTAT);
  assign show_io   = (st_q == dshd_pkg::ST_SHOW) && io_toggle_item;

  always_comb begin
    st_d = st_q;
    case (st_q)
      dshd_pkg::ST_RUN:  if (i_key_enter) st_d = dshd_pkg::ST_MENU;
      dshd_pkg::ST_MENU: begin
        if (i_key_enter && menu_open_ok) st_d = dshd_pkg::ST_LIST;
        else if (i_key_return) st_d = dshd_pkg::ST_RUN;
      end
      dshd_pkg::ST_LIST: begin
        if (i_key_enter) st_d = dshd_pkg::ST_SHOW;
        else if (i_key_return) st_d = dshd_pkg::ST_MENU;
      end
      dshd_pkg::ST_SHOW: if (i_key_return) st_d = dshd_pkg::ST_LIST;
      default: st_d = dshd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= dshd_pkg::ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // menu and item cursors wrap at either end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      menu_q <= 3'h0;
      item_q <= 5'h00;
    end else if (st_q == dshd_pkg::ST_MENU) begin
      item_q <= 5'h00;
      if (i_key_up) menu_q <= menu_q + 3'h1;
      else if (i_key_down) menu_q <= menu_q - 3'h1;
    end else if (st_q == dshd_pkg::ST_LIST) begin
      if (i_key_up) item_q <= (item_q == item_last) ? 5'h00 : item_q + 5'h01;
      else if (i_key_down) item_q <= (item_q == 5'h00) ? item_last : item_q - 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hex_q <= 1'b0;
    end else if (st_q == dshd_pkg::ST_LIST && i_key_enter) begin
      hex_q <= 1'b0;
    end else if (show_io && (i_key_up || i_key_down)) begin
      hex_q <= ~hex_q;
    end
  end

  // ---------------- display ----------------
  logic [15:0] io_word;
  logic [6:0]  led4_d;
  logic [6:0]  led3_d;
  logic [6:0]  led2_d;
  logic [6:0]  led1_d;
  assign io_word = (item_q == dshd_pkg::ITEM_IO_COMM) ? i_io_comm_terminals : i_io_terminals;

  assign led4_d = show_stat ? hex2seg(status_q[15:12]) :
                  (show_io && hex_q) ? hex2seg(io_word[15:12]) :
                  show_io ? nib2bar(io_word[15:12]) :
                  (st_q == dshd_pkg::ST_RUN) ? dshd_pkg::SEG_DASH :
                  hex2seg({1'b0, menu_q});
  assign led3_d = show_stat ? hex2seg(status_q[11:8]) :
                  (show_io && hex_q) ? hex2seg(io_word[11:8]) :
                  show_io ? nib2bar(io_word[11:8]) :
                  (st_q == dshd_pkg::ST_RUN) ? dshd_pkg::SEG_DASH :
                  dshd_pkg::SEG_UNDER;
  assign led2_d = show_stat ? hex2seg(status_q[7:4]) :
                  (show_io && hex_q) ? hex2seg(io_word[7:4]) :
                  show_io ? nib2bar(io_word[7:4]) :
                  (st_q == dshd_pkg::ST_LIST) ? hex2seg({3'h0, item_q[4]}) :
                  (st_q == dshd_pkg::ST_RUN) ? dshd_pkg::SEG_DASH : dshd_pkg::SEG_BLANK;
  assign led1_d = show_stat ? hex2seg(status_q[3:0]) :
                  (show_io && hex_q) ? hex2seg(io_word[3:0]) :
                  show_io ? nib2bar(io_word[3:0]) :
                  (st_q == dshd_pkg::ST_LIST) ? hex2seg(item_q[3:0]) :
                  (st_q == dshd_pkg::ST_RUN) ? dshd_pkg::SEG_DASH : dshd_pkg::SEG_BLANK;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_led4      <= dshd_pkg::SEG_BLANK;
      o_led3      <= dshd_pkg::SEG_BLANK;
      o_led2      <= dshd_pkg::SEG_BLANK;
      o_led1      <= dshd_pkg::SEG_BLANK;
      o_prog_mode <= 1'b0;
    end else begin
      o_led4      <= led4_d;
      o_led3      <= led3_d;
      o_led2      <= led2_d;
      o_led1      <= led1_d;
      o_prog_mode <= (st_d != dshd_pkg::ST_RUN);
    end
  end

  // ---------------- assertions ----------------
  sequence s_show_ret;
    (st_q == dshd_pkg::ST_SHOW) && i_key_return;
  endsequence
  sequence s_list_ret;
    (st_q == dshd_pkg::ST_LIST) && i_key_return && !i_key_enter;
  endsequence

  a_zero_bits_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_status_word[14:13] == 2'b00) else $error("bits 14 13 not zero");
  a_busy_follows: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_nrst && i_param_writing |=> o_status_word[15]) else $error("busy bit missed");
  a_alarm_tracks: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(i_alarm_flag) |=> o_status_word[11] && !$past(o_status_word[11]))
    else $error("alarm bit late");
  a_dir_bits: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    // a flag sampled while reset is low never reaches the status register
    $past(i_nrst) |-> o_status_word[1:0] == $past({i_backward_run, i_forward_run}))
    else $error("direction bits");
  a_enter_prog: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_q == dshd_pkg::ST_RUN) && i_key_enter |=> (st_q == dshd_pkg::ST_MENU) ##0 o_prog_mode)
    else $error("enter did not open menu");
  a_return_twice: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_show_ret ##2 s_list_ret |=> (st_q == dshd_pkg::ST_MENU)) else $error("return walk");
  a_scope_gate: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_q == dshd_pkg::ST_MENU) && (scope_q != dshd_pkg::SCOPE_FULL) &&
    ((menu_q == dshd_pkg::MENU_DRIVE) || (menu_q == dshd_pkg::MENU_IO))
    |=> (st_q != dshd_pkg::ST_LIST)) else $error("scope gate");
  a_hex_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    show_io && i_key_up && !i_key_return |=> hex_q != $past(hex_q)) else $error("view toggle");
  a_digit_left: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    show_stat |=> o_led4 == hex2seg($past(status_q[15:12])) &&
                  o_led1 == hex2seg($past(status_q[3:0]))) else $error("digit order");
  a_glyph_b: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    show_stat && (status_q[3:0] == 4'hb) |=> o_led1 == dshd_pkg::SEG_B) else $error("glyph b");
endmodule
`default_nettype wire

// ===== tb/dshd_keypad.sv
// Purpose: operator keypad model, one pulse per requested key press
// Assumes: bench calls press() from its main sequence only
// Notes:   each press leaves an idle cycle after it, so pulses never merge
`timescale 1ns/1ps
`default_nettype none
module dshd_keypad (
  input  wire logic i_ref_clk,
  output logic      o_key_enter,
  output logic      o_key_return,
  output logic      o_key_up,
  output logic      o_key_down
);
  logic [3:0] keys_q;
  assign {o_key_down, o_key_up, o_key_return, o_key_enter} = keys_q;
  initial keys_q = 4'h0;
  // k: 0 enter, 1 return, 2 up, 3 down
  task automatic press(input logic [1:0] k);
    @(posedge i_ref_clk);
    keys_q[k] <= 1'b1;
    @(posedge i_ref_clk);
    keys_q <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb/dshd_top_tb.sv
// Purpose: self-checking bench for the drive status hex display
// Assumes: keys come from the keypad model, registers over apb
// Notes:   menu and item numbers are read back to steer the walk and checked in panel reads
`timescale 1ns/1ps
`default_nettype none
module dshd_top_tb;
  localparam logic [6:0] GL [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                   7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic        i_ref_clk;
  logic        i_nrst;
  logic [13:0] fl;
  logic [15:0] io0;
  logic [15:0] io1;
  logic        k_ent;
  logic        k_ret;
  logic        k_up;
  logic        k_dn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [15:0] o_status_word;
  logic [6:0]  o_led4;
  logic [6:0]  o_led3;
  logic [6:0]  o_led2;
  logic [6:0]  o_led1;
  logic        o_prog_mode;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          cmp_count;

  dshd_top DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_param_writing(fl[13]),
    .i_comm_link_ready(fl[12]), .i_alarm_flag(fl[11]), .i_slowing_down(fl[10]),
    .i_speeding_up(fl[9]), .i_current_limit_active(fl[8]), .i_voltage_limit_active(fl[7]),
    .i_torque_limit_active(fl[6]), .i_bus_above_undervoltage(fl[5]),
    .i_braking_active(fl[4]), .i_output_shutdown(fl[3]), .i_dc_brake_active(fl[2]),
    .i_backward_run(fl[1]), .i_forward_run(fl[0]), .i_io_terminals(io0),
    .i_io_comm_terminals(io1), .i_key_enter(k_ent), .i_key_return(k_ret), .i_key_up(k_up),
    .i_key_down(k_dn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_status_word(o_status_word), .o_led4(o_led4), .o_led3(o_led3),
    .o_led2(o_led2), .o_led1(o_led1), .o_prog_mode(o_prog_mode));
  dshd_keypad kp (.i_ref_clk(i_ref_clk), .o_key_enter(k_ent), .o_key_return(k_ret),
    .o_key_up(k_up), .o_key_down(k_dn));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [15:0] sw(input logic [13:0] f);
    return {f[13], 2'b00, f[12:0]};
  endfunction
  function automatic logic [31:0] pn(input logic [3:0] s, input logic [2:0] m,
                                     input logic [4:0] it, input logic h);
    return 32'({h, it, m, s});
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // master holds the request until the rising edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
    rd = o_prdata;
    er = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic key(input logic [1:0] k);
    kp.press(k);
    @(negedge i_ref_clk);
  endtask
  task automatic st_chk(input logic [3:0] s);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("panel state", 32'(s), 32'(rd[3:0]));
  endtask
  task automatic steer(input int unsigned lsb, input logic [31:0] m, input logic [4:0] t);
    for (int n = 0; n < 24; n++) begin
      apb(1'b0, 8'h08, 32'h0000_0000);
      if (((rd >> lsb) & m) === 32'(t)) return;
      kp.press(2'd2);
    end
    err_total++;
    end_sim();
  endtask
  // digits are registered from the state register, one edge behind a key
  task automatic settle();
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic chk_leds(input logic [15:0] w);
    settle();
    chk("led4", 32'(GL[w[15:12]]), 32'(o_led4));
    chk("led3", 32'(GL[w[11:8]]), 32'(o_led3));
    chk("led2", 32'(GL[w[7:4]]), 32'(o_led2));
    chk("led1", 32'(GL[w[3:0]]), 32'(o_led1));
  endtask

  task automatic t_reset();
    chk("status", 32'(sw(fl)), 32'(o_status_word));
    chk("led4 dash", 32'h0000_0040, 32'(o_led4));
    chk("prog", 32'h0000_0000, 32'(o_prog_mode));
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    key(2'd0);
    chk("prog", 32'h0000_0001, 32'(o_prog_mode));
    st_chk(4'h2);
    $display("test reset done");
  endtask
  task automatic t_flags();
    for (int i = 0; i <= 14; i++) begin
      @(posedge i_ref_clk);
      fl <= (i == 14) ? 14'h3fff : 14'(1 << i);
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk("status", 32'(sw(fl)), 32'(o_status_word));
    end
    apb(1'b1, 8'h04, 32'h0000_ffff);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("status reg", 32'h0000_9fff, rd);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(er));
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test flags done");
  endtask
  task automatic t_gate();
    steer(4, 32'h0000_0007, 5'h03);
    key(2'd0);
    st_chk(4'h2);
    apb(1'b1, 8'h00, 32'h0000_0002);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl", 32'h0000_0002, rd);
    key(2'd0);
    st_chk(4'h4);
    $display("test gate done");
  endtask
  task automatic t_hexshow();
    logic [3:0] n;
    steer(7, 32'h0000_001f, 5'h07);
    key(2'd0);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("panel", pn(4'h8, 3'h3, 5'h07, 1'b0), rd);
    for (int i = 0; i < 16; i++) begin
      n = 4'(i);
      @(posedge i_ref_clk);
      fl <= {n[3], n[0], n, n, n};
      repeat (2) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk_leds({n[3], 2'b00, n[0], n, n, n});
    end
    key(2'd1);
    st_chk(4'h4);
    key(2'd1);
    st_chk(4'h2);
    $display("test hex show done");
  endtask
  task automatic t_io();
    steer(4, 32'h0000_0007, 5'h04);
    key(2'd0);
    steer(7, 32'h0000_001f, 5'h00);
    key(2'd0);
    key(2'd2);
    chk_leds(io0);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("panel", pn(4'h8, 3'h4, 5'h00, 1'b1), rd);
    key(2'd3);
    settle();
    chk("seg led1", 32'h0000_0003, 32'(o_led1));
    st_chk(4'h8);
    chk("hex off", 32'h0000_0000, 32'(rd[12]));
    key(2'd1);
    steer(7, 32'h0000_001f, 5'h01);
    key(2'd0);
    key(2'd3);
    chk_leds(io1);
    key(2'd1);
    key(2'd1);
    st_chk(4'h2);
    $display("test io done");
  endtask
  task automatic t_rerun();
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    @(negedge i_ref_clk);
    chk("reset status", 32'h0000_0000, 32'(o_status_word));
    chk("reset led4", 32'h0000_0000, 32'(o_led4));
    chk("reset prog", 32'h0000_0000, 32'(o_prog_mode));
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("rerun led4", 32'h0000_0040, 32'(o_led4));
    chk("rerun status", 32'(sw(fl)), 32'(o_status_word));
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("rerun ctrl", 32'h0000_0000, rd);
    st_chk(4'h1);
    $display("test rerun done");
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    i_nrst    = 1'b0;
    fl        = 14'h2a5a;
    io0       = 16'ha5c3;
    io1       = 16'h0bd7;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    repeat (3) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    t_reset();
    t_flags();
    t_gate();
    t_hexshow();
    t_io();
    t_rerun();
    end_sim();
  end
endmodule
`default_nettype wire
